//--- rtl/foa_alert_logic.v
// Fault enables, offset trims, threshold LSBs, fault outputs and combined alert
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`default_nettype none
module foa_alert_logic
#(
  parameter TW = 10
)
(
  input  wire          CLK_I,
  input  wire          NRST_I,
  input  wire [7:0]    REG_ADDR_I,
  input  wire [7:0]    REG_WDATA_I,
  input  wire          REG_WR_I,
  input  wire          REG_RD_I,
  output reg  [7:0]    REG_RDATA_O,
  input  wire          TEMP_VALID_I,
  input  wire [TW-1:0] INT_TEMP_I,
  input  wire [7:0]    INT_PRI_THR_MSB_I,
  input  wire [7:0]    INT_SEC_THR_MSB_I,
  input  wire [TW-1:0] RMT1_RAW_I,
  input  wire [TW-1:0] RMT2_RAW_I,
  input  wire [TW-1:0] RMT1_PRI_THR_I,
  input  wire [TW-1:0] RMT2_PRI_THR_I,
  input  wire          RMT1_DIODE_FAULT_I,
  input  wire          RMT2_DIODE_FAULT_I,
  input  wire          PRI_OC_CMP_I,
  input  wire          CS_VALID_I,
  input  wire [7:0]    CS_RESULT_I,
  input  wire [7:0]    CS_SEC_THR_I,
  input  wire          RESET_OUT_N_I,
  input  wire          GENERAL_FAULT_OUT_A_N_I,
  input  wire          GENERAL_FAULT_OUT_B_N_I,
  input  wire          GENERAL_PIN_A_I,
  input  wire          GENERAL_PIN_B_I,
  output wire          GENERAL_PIN_A_O,
  output wire          GENERAL_PIN_A_OE_O,
  output wire          GENERAL_PIN_B_O,
  output wire          GENERAL_PIN_B_OE_O,
  output wire          MANUAL_RESET_A_O,
  output wire          MANUAL_RESET_B_O,
  output reg  [TW-1:0] RMT1_TEMP_O,
  output reg  [TW-1:0] RMT2_TEMP_O,
  output reg           INT_SEC_OT_O,
  output reg           SEC_OC_FAULT_O,
  output reg           OVERTEMP_FAULT_OUT_N_O,
  output reg           OVERCURRENT_FAULT_OUT_N_O,
  output reg           ALERT_N_O
);
`include "foa_defs.vh"
// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
reg  [7:0]    fault_en;
reg  [7:0]    thr_lsb;
reg  [7:0]    pin_cfg;
reg  [7:0]    oc_cfg;
reg  [6:0]    flags;
reg  [6:0]    next_flags;
reg  [6:0]    flag_set;
reg  [6:0]    flag_clr;
reg  [3:0]    soc_cnt;
reg  [3:0]    soc_need;
reg           oc_latch;
reg           int_pri_ot;
reg           rmt1_pri_ot;
reg           rmt2_pri_ot;
wire          wr_en;
wire          en_int;
wire          en_rmt1;
wire          en_rmt2;
wire          en_cur;
wire          one_hot;
wire [TW-1:0] trim1;
wire [TW-1:0] trim2;
wire [TW-1:0] rmt1_corr;
wire [TW-1:0] rmt2_corr;
wire [TW-1:0] int_pri_thr;
wire [TW-1:0] int_sec_thr;
wire          oc_clear;
wire          soc_over;
wire          ot_active;
wire          oc_active;
wire          pin_a_fault;
wire          pin_b_fault;
wire          pin_a_in;
wire          pin_b_in;
wire          alert_any;
assign wr_en   = REG_WR_I;
assign en_int  = fault_en[`FOA_EN_INT];
assign en_rmt1 = fault_en[`FOA_EN_RMT1];
assign en_rmt2 = fault_en[`FOA_EN_RMT2];
assign en_cur  = fault_en[`FOA_EN_CUR];
// ----------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------
always @(posedge CLK_I)
begin
  if (!NRST_I)
  begin
    fault_en <= `FOA_RST_FAULT_EN;
    thr_lsb  <= `FOA_RST_THR_LSB;
    pin_cfg  <= `FOA_RST_PIN_CFG;
    oc_cfg   <= `FOA_RST_OC_CFG;
  end
  else if (wr_en)
  begin
    case (REG_ADDR_I)
      `FOA_ADDR_FAULT_EN: fault_en <= REG_WDATA_I;
      `FOA_ADDR_THR_LSB:  thr_lsb  <= {1'b0, REG_WDATA_I[6:0]};
      `FOA_ADDR_PIN_CFG:  pin_cfg  <= REG_WDATA_I;
      `FOA_ADDR_OC_CFG:   oc_cfg   <= {5'h0_0, REG_WDATA_I[2:0]};
      default:            fault_en <= fault_en;
    endcase
  end
end
// ----------------------------------------------------------------
// Offset trims and threshold assembly
// ----------------------------------------------------------------
// sign-extend, times four
assign trim1 = {{(TW-5){fault_en[`FOA_TRIM1_HI]}}, fault_en[`FOA_TRIM1_HI:`FOA_TRIM1_LO], 2'b00};
assign trim2 = {{(TW-5){thr_lsb[`FOA_TRIM2_HI]}}, thr_lsb[`FOA_TRIM2_HI:`FOA_TRIM2_LO], 2'b00};
// Wraps rather than saturates at the code extremes
assign rmt1_corr = RMT1_RAW_I + trim1;
assign rmt2_corr = RMT2_RAW_I + trim2;
assign int_pri_thr = {INT_PRI_THR_MSB_I, thr_lsb[`FOA_PRI_LSB_HI:`FOA_PRI_LSB_LO]};
assign int_sec_thr = {INT_SEC_THR_MSB_I, thr_lsb[`FOA_SEC_LSB_HI:`FOA_SEC_LSB_LO]};
// ----------------------------------------------------------------
// Temperature comparisons, once per conversion round
// ----------------------------------------------------------------
always @(posedge CLK_I)
begin
  if (!NRST_I)
  begin
    RMT1_TEMP_O  <= {TW{1'b0}};
    RMT2_TEMP_O  <= {TW{1'b0}};
    int_pri_ot   <= 1'b0;
    rmt1_pri_ot  <= 1'b0;
    rmt2_pri_ot  <= 1'b0;
    INT_SEC_OT_O <= 1'b0;
  end
  else
  begin
    if (TEMP_VALID_I)
    begin
      RMT1_TEMP_O  <= rmt1_corr;
      RMT2_TEMP_O  <= rmt2_corr;
      int_pri_ot   <= en_int && (INT_TEMP_I >= int_pri_thr);
      INT_SEC_OT_O <= en_int && (INT_TEMP_I >= int_sec_thr);
      rmt1_pri_ot  <= en_rmt1 && (rmt1_corr >= RMT1_PRI_THR_I);
      rmt2_pri_ot  <= en_rmt2 && (rmt2_corr >= RMT2_PRI_THR_I);
    end
    else
    begin
      // Disabling a sensor drops its fault at once
      int_pri_ot   <= int_pri_ot && en_int;
      INT_SEC_OT_O <= INT_SEC_OT_O && en_int;
      rmt1_pri_ot  <= rmt1_pri_ot && en_rmt1;
      rmt2_pri_ot  <= rmt2_pri_ot && en_rmt2;
    end
  end
end
// ----------------------------------------------------------------
// Secondary overcurrent with programmable delay
// ----------------------------------------------------------------
always @*
begin
  case (oc_cfg[`FOA_OC_DLY_HI:`FOA_OC_DLY_LO])
    2'h0:    soc_need = `FOA_SOC_DLY0;
    2'h1:    soc_need = `FOA_SOC_DLY1;
    2'h2:    soc_need = `FOA_SOC_DLY2;
    2'h3:    soc_need = `FOA_SOC_DLY3;
    default: soc_need = `FOA_SOC_DLY0;
  endcase
end
assign soc_over = en_cur && (CS_RESULT_I > CS_SEC_THR_I);
always @(posedge CLK_I)
begin
  if (!NRST_I)
  begin
    soc_cnt        <= 4'h0;
    SEC_OC_FAULT_O <= 1'b0;
  end
  else if (!en_cur)
  begin
    soc_cnt        <= 4'h0;
    SEC_OC_FAULT_O <= 1'b0;
  end
  else if (CS_VALID_I)
  begin
    if (!soc_over)
    begin
      soc_cnt        <= 4'h0;
      SEC_OC_FAULT_O <= 1'b0;
    end
    else
    begin
      if (soc_cnt < soc_need)
        soc_cnt <= soc_cnt + 4'h1;
      SEC_OC_FAULT_O <= ((soc_cnt + 4'h1) >= soc_need);
    end
  end
end
// ----------------------------------------------------------------
// Latched fault flags
// ----------------------------------------------------------------
// A single 1 in the written byte selects the flag to clear
assign one_hot = (REG_WDATA_I != 8'h00) && ((REG_WDATA_I & (REG_WDATA_I - 8'h01)) == 8'h00);
always @*
begin
  flag_set = 7'h00;
  flag_set[`FOA_FLAG_INT_OT]     = int_pri_ot;
  flag_set[`FOA_FLAG_RMT1_OT]    = rmt1_pri_ot;
  flag_set[`FOA_FLAG_RMT2_OT]    = rmt2_pri_ot;
  flag_set[`FOA_FLAG_RMT1_DIODE] = en_rmt1 && RMT1_DIODE_FAULT_I;
  flag_set[`FOA_FLAG_RMT2_DIODE] = en_rmt2 && RMT2_DIODE_FAULT_I;
  flag_set[`FOA_FLAG_SEC_OC]     = SEC_OC_FAULT_O;
  flag_set[`FOA_FLAG_PRI_OC]     = en_cur && PRI_OC_CMP_I;
  flag_clr = 7'h00;
  if (wr_en && (REG_ADDR_I == `FOA_ADDR_FLAGS) && one_hot)
    flag_clr = REG_WDATA_I[6:0];
  // Set wins so a coincident event is never lost
  next_flags = (flags & ~flag_clr) | flag_set;
end
always @(posedge CLK_I)
begin
  if (!NRST_I)
    flags <= `FOA_RST_FLAGS;
  else
    flags <= next_flags;
end
// ----------------------------------------------------------------
// Overtemperature and overcurrent outputs
// ----------------------------------------------------------------
// diode flags hold output low
assign ot_active = int_pri_ot || rmt1_pri_ot || rmt2_pri_ot
                 || flags[`FOA_FLAG_RMT1_DIODE] || flags[`FOA_FLAG_RMT2_DIODE];
assign oc_clear = wr_en && (REG_ADDR_I == `FOA_ADDR_OC_CLEAR) && REG_WDATA_I[`FOA_OC_CLR_BIT];
always @(posedge CLK_I)
begin
  if (!NRST_I)
    oc_latch <= 1'b0;
  else if (en_cur && PRI_OC_CMP_I && oc_cfg[`FOA_OC_LATCH_BIT])
    oc_latch <= 1'b1;
  else if (oc_clear || !oc_cfg[`FOA_OC_LATCH_BIT] || !en_cur)
    oc_latch <= 1'b0;
end
assign oc_active = en_cur && (PRI_OC_CMP_I || oc_latch);
always @(posedge CLK_I)
begin
  if (!NRST_I)
  begin
    OVERTEMP_FAULT_OUT_N_O    <= 1'b1;
    OVERCURRENT_FAULT_OUT_N_O <= 1'b1;
  end
  else
  begin
    OVERTEMP_FAULT_OUT_N_O    <= ~ot_active;
    OVERCURRENT_FAULT_OUT_N_O <= ~oc_active;
  end
end
// ----------------------------------------------------------------
// General-purpose pins
// ----------------------------------------------------------------
// Fault select bit picks overtemp (0) or overcurrent (1)
foa_gpio_pin u_pin_a
(
  .clk_i       (CLK_I),
  .nrst_i      (NRST_I),
  .mode_i      (pin_cfg[1:0]),
  .out_level_i (pin_cfg[4]),
  .fault_i     (pin_cfg[6] ? oc_active : ot_active),
  .pin_i       (GENERAL_PIN_A_I),
  .pin_o       (GENERAL_PIN_A_O),
  .pin_oe_o    (GENERAL_PIN_A_OE_O),
  .mreset_o    (MANUAL_RESET_A_O),
  .in_level_o  (pin_a_in),
  .fault_low_o (pin_a_fault)
);
foa_gpio_pin u_pin_b
(
  .clk_i       (CLK_I),
  .nrst_i      (NRST_I),
  .mode_i      (pin_cfg[3:2]),
  .out_level_i (pin_cfg[5]),
  .fault_i     (pin_cfg[7] ? oc_active : ot_active),
  .pin_i       (GENERAL_PIN_B_I),
  .pin_o       (GENERAL_PIN_B_O),
  .pin_oe_o    (GENERAL_PIN_B_OE_O),
  .mreset_o    (MANUAL_RESET_B_O),
  .in_level_o  (pin_b_in),
  .fault_low_o (pin_b_fault)
);
// ----------------------------------------------------------------
// Combined alert
// ----------------------------------------------------------------
// AND of active-low fault lines
assign alert_any = ~(RESET_OUT_N_I & GENERAL_FAULT_OUT_A_N_I & GENERAL_FAULT_OUT_B_N_I
                   & OVERTEMP_FAULT_OUT_N_O & OVERCURRENT_FAULT_OUT_N_O
                   & ~pin_a_fault & ~pin_b_fault);
always @(posedge CLK_I)
begin
  if (!NRST_I)
    ALERT_N_O <= 1'b1;
  else
    ALERT_N_O <= ~(fault_en[`FOA_EN_ALERT] && alert_any);
end
// ----------------------------------------------------------------
// Register reads
// ----------------------------------------------------------------
// Unmapped and write-only addresses read zero
always @(posedge CLK_I)
begin
  if (!NRST_I)
    REG_RDATA_O <= 8'h00;
  else if (REG_RD_I)
  begin
    case (REG_ADDR_I)
      `FOA_ADDR_FAULT_EN: REG_RDATA_O <= fault_en;
      `FOA_ADDR_THR_LSB:  REG_RDATA_O <= thr_lsb;
      `FOA_ADDR_PIN_CFG:  REG_RDATA_O <= pin_cfg;
      `FOA_ADDR_OC_CFG:   REG_RDATA_O <= oc_cfg;
      `FOA_ADDR_FLAGS:    REG_RDATA_O <= {1'b0, flags};
      `FOA_ADDR_STATUS:   REG_RDATA_O <= {oc_latch, pin_b_in, pin_a_in, SEC_OC_FAULT_O, INT_SEC_OT_O,
                                          ~ALERT_N_O, ~OVERCURRENT_FAULT_OUT_N_O, ~OVERTEMP_FAULT_OUT_N_O};
      default:            REG_RDATA_O <= 8'h00;
    endcase
  end
end
// host-side query; nothing here beyond holding the alert low
endmodule // foa_alert_logic
`default_nettype wire

//--- rtl/foa_defs.vh
// Register map, field positions, reset values and counts of the fault-output block
`ifndef FOA_DEFS_VH
`define FOA_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define FOA_ADDR_FAULT_EN     8'h1B
`define FOA_ADDR_THR_LSB      8'h4D
`define FOA_ADDR_PIN_CFG      8'h22
`define FOA_ADDR_OC_CLEAR     8'h53
`define FOA_ADDR_OC_CFG       8'h5C
`define FOA_ADDR_FLAGS        8'h60
`define FOA_ADDR_STATUS       8'h61

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FOA_EN_INT            0
`define FOA_EN_RMT1           1
`define FOA_EN_RMT2           2
`define FOA_EN_CUR            3
`define FOA_EN_ALERT          4
`define FOA_TRIM1_HI          7
`define FOA_TRIM1_LO          5
`define FOA_PRI_LSB_HI        1
`define FOA_PRI_LSB_LO        0
`define FOA_SEC_LSB_HI        3
`define FOA_SEC_LSB_LO        2
`define FOA_TRIM2_HI          6
`define FOA_TRIM2_LO          4
`define FOA_OC_CLR_BIT        6
`define FOA_OC_LATCH_BIT      2
`define FOA_OC_DLY_HI         1
`define FOA_OC_DLY_LO         0
`define FOA_FLAG_INT_OT       0
`define FOA_FLAG_RMT1_OT      1
`define FOA_FLAG_RMT2_OT      2
`define FOA_FLAG_RMT1_DIODE   3
`define FOA_FLAG_RMT2_DIODE   4
`define FOA_FLAG_SEC_OC       5
`define FOA_FLAG_PRI_OC       6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FOA_RST_FAULT_EN      8'h00
`define FOA_RST_THR_LSB       8'h00
`define FOA_RST_PIN_CFG       8'h00
`define FOA_RST_OC_CFG        8'h00
`define FOA_RST_FLAGS         7'h00

// ----------------------------------------------------------------
// Pin modes and secondary overcurrent delay counts (conversions)
// ----------------------------------------------------------------
`define FOA_PIN_INPUT         2'h0
`define FOA_PIN_MRESET        2'h1
`define FOA_PIN_OUTPUT        2'h2
`define FOA_PIN_FAULT         2'h3
`define FOA_SOC_DLY0          4'h1
`define FOA_SOC_DLY1          4'h2
`define FOA_SOC_DLY2          4'h4
`define FOA_SOC_DLY3          4'h8

`endif

//--- rtl/foa_gpio_pin.v
// One open-drain general-purpose pin with its four modes
`default_nettype none

module foa_gpio_pin
(
  input  wire       clk_i,
  input  wire       nrst_i,
  input  wire [1:0] mode_i,
  input  wire       out_level_i,
  input  wire       fault_i,
  input  wire       pin_i,
  output reg        pin_o,
  output reg        pin_oe_o,
  output reg        mreset_o,
  output reg        in_level_o,
  output reg        fault_low_o
);

`include "foa_defs.vh"

// ----------------------------------------------------------------
// Pin drive and sampling
// ----------------------------------------------------------------
always @(posedge clk_i)
begin
  if (!nrst_i)
  begin
    pin_o       <= 1'b0;
    pin_oe_o    <= 1'b0;
    mreset_o    <= 1'b0;
    in_level_o  <= 1'b0;
    fault_low_o <= 1'b0;
  end
  else
  begin
    // Open drain: only ever pulls low
    pin_o      <= 1'b0;
    in_level_o <= pin_i;
    case (mode_i)
      `FOA_PIN_INPUT:
      begin
        pin_oe_o    <= 1'b0;
        mreset_o    <= 1'b0;
        fault_low_o <= 1'b0;
      end
      `FOA_PIN_MRESET:
      begin
        pin_oe_o    <= 1'b0;
        mreset_o    <= ~pin_i;
        fault_low_o <= 1'b0;
      end
      `FOA_PIN_OUTPUT:
      begin
        pin_oe_o    <= ~out_level_i;
        mreset_o    <= 1'b0;
        fault_low_o <= 1'b0;
      end
      `FOA_PIN_FAULT:
      begin
        pin_oe_o    <= fault_i;
        mreset_o    <= 1'b0;
        fault_low_o <= fault_i;
      end
      default:
      begin
        pin_oe_o    <= 1'b0;
        mreset_o    <= 1'b0;
        fault_low_o <= 1'b0;
      end
    endcase
  end
end

endmodule // foa_gpio_pin

`default_nettype wire

//--- test/foa_alert_chk_assertions.sv
// Port-level assertions of the fault-output and alert block
`default_nettype none

module foa_alert_chk
#(
  parameter TW = 10
)
(
  input wire logic          CLK_I,
  input wire logic          NRST_I,
  input wire logic [7:0]    REG_ADDR_I,
  input wire logic [7:0]    REG_WDATA_I,
  input wire logic          REG_WR_I,
  input wire logic          TEMP_VALID_I,
  input wire logic [TW-1:0] INT_TEMP_I,
  input wire logic [7:0]    INT_PRI_THR_MSB_I,
  input wire logic          RMT1_DIODE_FAULT_I,
  input wire logic          PRI_OC_CMP_I,
  input wire logic          CS_VALID_I,
  input wire logic [7:0]    CS_RESULT_I,
  input wire logic [7:0]    CS_SEC_THR_I,
  input wire logic          RESET_OUT_N_I,
  input wire logic          GENERAL_FAULT_OUT_A_N_I,
  input wire logic          GENERAL_FAULT_OUT_B_N_I,
  input wire logic          GENERAL_PIN_A_OE_O,
  input wire logic          OVERTEMP_FAULT_OUT_N_O,
  input wire logic          OVERCURRENT_FAULT_OUT_N_O,
  input wire logic          SEC_OC_FAULT_O,
  input wire logic          ALERT_N_O
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------
  // Register shadows
  // ----------------
  logic [7:0] en, thr, pcfg, occ;
  always @(posedge CLK_I)
  begin
    if (!NRST_I)
    begin
      en   <= 8'h00;
      thr  <= 8'h00;
      pcfg <= 8'h00;
      occ  <= 8'h00;
    end
    else if (REG_WR_I)
    begin
      if (REG_ADDR_I == 8'h1B) en <= REG_WDATA_I;
      if (REG_ADDR_I == 8'h4D) thr <= REG_WDATA_I;
      if (REG_ADDR_I == 8'h22) pcfg <= REG_WDATA_I;
      if (REG_ADDR_I == 8'h5C) occ <= REG_WDATA_I;
    end
  end
  // Any flag write counts as a clear, so the latch check stays conservative
  wire oc_clr   = REG_WR_I && (REG_ADDR_I == 8'h53) && REG_WDATA_I[6];
  wire fl_clr   = REG_WR_I && (REG_ADDR_I == 8'h60);
  wire pri_hit  = INT_TEMP_I >= {INT_PRI_THR_MSB_I, thr[1:0]};
  wire lines_ok = RESET_OUT_N_I && GENERAL_FAULT_OUT_A_N_I && GENERAL_FAULT_OUT_B_N_I
                  && OVERTEMP_FAULT_OUT_N_O && OVERCURRENT_FAULT_OUT_N_O;
  wire quiet    = lines_ok && (pcfg[1:0] != 2'h3) && (pcfg[3:2] != 2'h3);

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  // ----------------
  // Properties
  // ----------------
  property p_int_pri;
    en[0] && TEMP_VALID_I && pri_hit ##1 en[0] |=> !OVERTEMP_FAULT_OUT_N_O;
  endproperty
  a_int_pri: assert property (p_int_pri) else $error("overtemp missed internal hit");
  property p_diode;
    en[1] && RMT1_DIODE_FAULT_I ##1 (en[1] && !fl_clr)[*4] |=> !OVERTEMP_FAULT_OUT_N_O;
  endproperty
  a_diode: assert property (p_diode) else $error("diode latch released early");
  property p_oc_on;
    en[3] && PRI_OC_CMP_I |=> !OVERCURRENT_FAULT_OUT_N_O;
  endproperty
  a_oc_on: assert property (p_oc_on) else $error("overcurrent missed comparator");
  property p_oc_latch;
    en[3] && occ[2] && PRI_OC_CMP_I ##1 (en[3] && occ[2] && !oc_clr)[*3] |=> !OVERCURRENT_FAULT_OUT_N_O;
  endproperty
  a_oc_latch: assert property (p_oc_latch) else $error("overcurrent latch lost");
  property p_sec_oc;
    CS_VALID_I && (CS_RESULT_I <= CS_SEC_THR_I) |=> !SEC_OC_FAULT_O;
  endproperty
  a_sec_oc: assert property (p_sec_oc) else $error("secondary fault not cleared");
  property p_alert_off;
    !en[4] |=> ALERT_N_O;
  endproperty
  a_alert_off: assert property (p_alert_off) else $error("alert low while disabled");
  property p_alert_on;
    en[4] && !lines_ok |=> !ALERT_N_O;
  endproperty
  a_alert_on: assert property (p_alert_on) else $error("alert missed a fault line");
  property p_alert_rel;
    quiet ##1 quiet |=> ALERT_N_O;
  endproperty
  a_alert_rel: assert property (p_alert_rel) else $error("alert held without fault");
  property p_pin_flt;
    (pcfg[1:0] == 2'h3 && pcfg[6] && en[3] && PRI_OC_CMP_I)[*2] |=> GENERAL_PIN_A_OE_O;
  endproperty
  a_pin_flt: assert property (p_pin_flt) else $error("fault pin not driven");
endmodule // foa_alert_chk

bind foa_alert_logic foa_alert_chk #(.TW(TW)) chk_u
(
  .CLK_I, .NRST_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .TEMP_VALID_I, .INT_TEMP_I,
  .INT_PRI_THR_MSB_I, .RMT1_DIODE_FAULT_I, .PRI_OC_CMP_I, .CS_VALID_I, .CS_RESULT_I,
  .CS_SEC_THR_I, .RESET_OUT_N_I, .GENERAL_FAULT_OUT_A_N_I, .GENERAL_FAULT_OUT_B_N_I,
  .GENERAL_PIN_A_OE_O, .OVERTEMP_FAULT_OUT_N_O, .OVERCURRENT_FAULT_OUT_N_O,
  .SEC_OC_FAULT_O, .ALERT_N_O
);

`default_nettype wire

//--- test/foa_host_mdl.sv
// Bus host model that answers a falling alert with a source query
`default_nettype none

module foa_host_mdl
(
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic alert_n_i,
  output var  logic query_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic alert_q;
  always @(posedge clk_i)
  begin
    alert_q <= alert_n_i;
    query_o <= nrst_i && alert_q && !alert_n_i;
  end
endmodule // foa_host_mdl

`default_nettype wire

//--- test/tb.sv
// Self-checking bench of the fault-output and alert block
`default_nettype none

`define CHK(n, e, a) \
  begin tests_run++; if ((a) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, a); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk, nrst, reg_wr, reg_rd, tv, d1, d2, cmp, csv, rst_n, fa_n, fb_n, pa_ext, pb_ext;
  logic [7:0] addr, wdata, ipri, isec, csr, cst;
  logic [9:0] itemp, r1raw, r2raw, r1thr, r2thr;
  wire  [7:0] rdata;
  wire  [9:0] r1t, r2t;
  wire        pa_o, pa_oe, pb_o, pb_oe, mra, mrb, isot, soc, ot_n, oc_n, al_n, query;
  // Open-drain pins with pull-up
  wire        pa_in = pa_ext && !pa_oe;
  wire        pb_in = pb_ext && !pb_oe;
  int         fail_count, tests_run;
  logic [7:0] dut_addr [6] = '{8'h1B, 8'h4D, 8'h22, 8'h5C, 8'h60, 8'h7F};

  foa_alert_logic #(.TW(10)) dut_u
  (
    .CLK_I(clk), .NRST_I(nrst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(reg_wr),
    .REG_RD_I(reg_rd), .REG_RDATA_O(rdata), .TEMP_VALID_I(tv), .INT_TEMP_I(itemp),
    .INT_PRI_THR_MSB_I(ipri), .INT_SEC_THR_MSB_I(isec), .RMT1_RAW_I(r1raw), .RMT2_RAW_I(r2raw),
    .RMT1_PRI_THR_I(r1thr), .RMT2_PRI_THR_I(r2thr), .RMT1_DIODE_FAULT_I(d1), .RMT2_DIODE_FAULT_I(d2),
    .PRI_OC_CMP_I(cmp), .CS_VALID_I(csv), .CS_RESULT_I(csr), .CS_SEC_THR_I(cst), .RESET_OUT_N_I(rst_n),
    .GENERAL_FAULT_OUT_A_N_I(fa_n), .GENERAL_FAULT_OUT_B_N_I(fb_n), .GENERAL_PIN_A_I(pa_in),
    .GENERAL_PIN_B_I(pb_in), .GENERAL_PIN_A_O(pa_o), .GENERAL_PIN_A_OE_O(pa_oe), .GENERAL_PIN_B_O(pb_o),
    .GENERAL_PIN_B_OE_O(pb_oe), .MANUAL_RESET_A_O(mra), .MANUAL_RESET_B_O(mrb), .RMT1_TEMP_O(r1t),
    .RMT2_TEMP_O(r2t), .INT_SEC_OT_O(isot), .SEC_OC_FAULT_O(soc), .OVERTEMP_FAULT_OUT_N_O(ot_n),
    .OVERCURRENT_FAULT_OUT_N_O(oc_n), .ALERT_N_O(al_n)
  );
  foa_host_mdl host_u (.clk_i(clk), .nrst_i(nrst), .alert_n_i(al_n), .query_o(query));

  // ----------------
  // Access tasks
  // ----------------
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // A gap cycle after each strobe keeps drivers from double assignment
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    `CHK("rdata", e, rdata)
    @(negedge clk);
  endtask
  task automatic temp_conv(input logic [9:0] t);
    itemp = t;
    tv = 1'b1;
    @(negedge clk);
    tv = 1'b0;
    tick(3);
  endtask
  task automatic cs_conv(input logic [7:0] r);
    csr = r;
    csv = 1'b1;
    @(negedge clk);
    csv = 1'b0;
    tick(2);
  endtask
  task automatic close_out;
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_query;
    int n;
    n = 0;
    while (query !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    if (query !== 1'b1)
    begin
      fail_count++;
      close_out();
    end
  endtask

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------
  // Scenarios
  // ----------------
  initial
  begin
    {nrst, reg_wr, reg_rd, tv, d1, d2, cmp, csv} = '0;
    {rst_n, fa_n, fb_n, pa_ext, pb_ext} = '1;
    {addr, wdata, ipri, isec, csr, cst} = '0;
    {itemp, r1raw, r2raw} = '0;
    {r1thr, r2thr} = '1;
    fail_count = 0;
    tests_run = 0;
    tick(4);
    nrst = 1'b1;
    foreach (dut_addr[i]) rd(dut_addr[i], 8'h00);
    `CHK("alert", 1'b1, al_n)
    wr(8'h1B, 8'hA5);
    rd(8'h1B, 8'hA5);
    wr(8'h4D, 8'hFF);
    rd(8'h4D, 8'h7F);
    wr(8'h53, 8'h40);
    rd(8'h53, 8'h00);
    // Trim -1 and +3, then -4 to wrap past the bottom code and +3 past the top
    wr(8'h1B, 8'hE0);
    wr(8'h4D, 8'h30);
    {r1raw, r2raw} = {10'h064, 10'h064};
    temp_conv(10'h000);
    `CHK("rmt1", 10'h060, r1t)
    `CHK("rmt2", 10'h070, r2t)
    wr(8'h1B, 8'h80);
    {r1raw, r2raw} = {10'h00A, 10'h3FF};
    temp_conv(10'h000);
    `CHK("rmt1", 10'h3FA, r1t)
    `CHK("rmt2", 10'h00B, r2t)
    {r1raw, r2raw} = '0;
    // Thresholds 0x102 primary and 0x103 secondary
    {ipri, isec} = {8'h40, 8'h40};
    wr(8'h4D, 8'h0E);
    wr(8'h1B, 8'h11);
    temp_conv(10'h101);
    `CHK("overtemp", 1'b1, ot_n)
    temp_conv(10'h102);
    `CHK("overtemp", 1'b0, ot_n)
    `CHK("int_sec", 1'b0, isot)
    `CHK("alert", 1'b0, al_n)
    temp_conv(10'h103);
    `CHK("int_sec", 1'b1, isot)
    rd(8'h60, 8'h01);
    temp_conv(10'h000);
    wr(8'h60, 8'h03);
    rd(8'h60, 8'h01);
    wr(8'h60, 8'h01);
    rd(8'h60, 8'h00);
    wr(8'h1B, 8'h10);
    temp_conv(10'h3FF);
    `CHK("overtemp", 1'b1, ot_n)
    `CHK("alert", 1'b1, al_n)
    rd(8'h60, 8'h00);
    // Diode fault on enabled sensor 1, disabled sensor 2
    wr(8'h1B, 8'h02);
    {d1, d2} = 2'b11;
    @(negedge clk);
    d1 = 1'b0;
    tick(5);
    `CHK("overtemp", 1'b0, ot_n)
    rd(8'h60, 8'h08);
    d2 = 1'b0;
    wr(8'h60, 8'h08);
    tick(2);
    `CHK("overtemp", 1'b1, ot_n)
    wr(8'h1B, 8'h04);
    d2 = 1'b1;
    @(negedge clk);
    d2 = 1'b0;
    tick(2);
    rd(8'h60, 8'h10);
    wr(8'h60, 8'h10);
    // Primary overcurrent, plain then latched
    wr(8'h1B, 8'h08);
    cmp = 1'b1;
    tick(2);
    `CHK("overcurrent", 1'b0, oc_n)
    cmp = 1'b0;
    tick(2);
    `CHK("overcurrent", 1'b1, oc_n)
    wr(8'h5C, 8'h04);
    cmp = 1'b1;
    @(negedge clk);
    cmp = 1'b0;
    tick(3);
    `CHK("overcurrent", 1'b0, oc_n)
    wr(8'h53, 8'h40);
    tick(2);
    `CHK("overcurrent", 1'b1, oc_n)
    wr(8'h1B, 8'h00);
    cmp = 1'b1;
    tick(2);
    `CHK("overcurrent", 1'b1, oc_n)
    cmp = 1'b0;
    // Secondary overcurrent needs four hits at delay code 2
    wr(8'h1B, 8'h08);
    wr(8'h5C, 8'h02);
    cst = 8'h80;
    for (int i = 1; i <= 4; i++)
    begin
      cs_conv(8'h81);
      `CHK("sec_oc", i == 4, soc)
    end
    cs_conv(8'h80);
    `CHK("sec_oc", 1'b0, soc)
    // Alert gating and each external fault line
    wr(8'h1B, 8'h00);
    fa_n = 1'b0;
    tick(2);
    `CHK("alert", 1'b1, al_n)
    fa_n = 1'b1;
    wr(8'h1B, 8'h10);
    for (int i = 0; i < 3; i++)
    begin
      {rst_n, fa_n, fb_n} = ~(3'b001 << i);
      wait_query();
      `CHK("alert", 1'b0, al_n)
      {rst_n, fa_n, fb_n} = 3'b111;
      tick(3);
      `CHK("alert", 1'b1, al_n)
    end
    // Pin modes
    wr(8'h22, 8'h02);
    tick(1);
    `CHK("pin_oe", 1'b1, pa_oe)
    `CHK("pin_o", 1'b0, pa_o)
    `CHK("pinb_o", 1'b0, pb_o)
    `CHK("alert", 1'b1, al_n)
    wr(8'h22, 8'h12);
    `CHK("pin_oe", 1'b0, pa_oe)
    wr(8'h22, 8'h05);
    {pa_ext, pb_ext} = 2'b00;
    tick(2);
    `CHK("mreset", 1'b1, mra)
    `CHK("mresetb", 1'b1, mrb)
    wr(8'h22, 8'h00);
    `CHK("pin_oe", 1'b0, pa_oe)
    {pa_ext, pb_ext} = 2'b11;
    wr(8'h22, 8'h4F);
    wr(8'h1B, 8'h18);
    cmp = 1'b1;
    tick(3);
    `CHK("pin_oe", 1'b1, pa_oe)
    `CHK("pinb_oe", 1'b0, pb_oe)
    `CHK("alert", 1'b0, al_n)
    rd(8'h61, 8'h46);
    cmp = 1'b0;
    tick(3);
    `CHK("pin_oe", 1'b0, pa_oe)
    close_out();
  end
endmodule // tb

`default_nettype wire
